// >>> test/bus_peripheral_model.sv
// Behavioural peripheral on the expansion bus: read data and wait stretch.
// Assumes pins change on ref_clk edges and the bench sets stall_cycles before each access.
`timescale 1ns/1ps
`default_nettype none
`include "exp_defs.svh"
module bus_peripheral_model
  import exp_pkg::*;
(
  input  wire logic [`EXP_ADDR_W-1:0] addr_out,
  input  wire logic                   ref_clk,
  input  wire logic                   chip_select_n,
  input  wire logic                   split_read_strobe_n,
  input  wire logic                   data_strobe_n,
  input  wire logic                   read_not_write,
  input  wire logic [7:0]             stall_cycles,
  output logic [`EXP_DATA_W-1:0]      data_in,
  output logic                        slow_device_wait_n
);
  logic [`EXP_ADDR_W-1:0] seen_addr_r = 24'h000000;
  logic [`EXP_DATA_W-1:0] noise_r     = 16'h5A3C;
  logic [7:0]             stall_r     = 8'h00;
  logic                   in_acc_r    = 1'b0;
  logic                   rd_on;

  // Address taken while shown ahead of select, so mux mode works as well
  always @(posedge ref_clk)
  begin
    noise_r <= noise_r + 16'h3B1D;
    if (chip_select_n === 1'b1 && addr_out != 24'h000000)
      seen_addr_r <= addr_out;
    in_acc_r <= (chip_select_n === 1'b0);
    if (chip_select_n === 1'b0 && !in_acc_r)
      stall_r <= stall_cycles;
    else if (stall_r != 8'h00)
      stall_r <= stall_r - 8'h01;
  end

  // Undriven bus shows a changing pattern, never the last word
  assign rd_on = split_read_strobe_n === 1'b0 || (data_strobe_n === 1'b0 && read_not_write);
  assign data_in = rd_on ? ({seen_addr_r[7:0], seen_addr_r[15:8]} ^ 16'hA5C3) : noise_r;
  // Wait is raised from the second select cycle, well ahead of strobe release
  assign slow_device_wait_n = (stall_r == 8'h00);
endmodule  // bus_peripheral_model
`default_nettype wire

// >>> test/test_expansion_bus_async_strobe_timing.sv
// Self-checking bench: tallies pin phases of each access against the lengths.
// Assumes the design files and the peripheral model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_expansion_bus_async_strobe_timing;
  logic        ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic [1:0]  bus_mode = 2'h0, address_phase_len = 2'h0;
  logic [1:0]  data_setup_phase_len = 2'h0, hold_phase_len = 2'h0;
  logic [3:0]  strobe_phase_len = 4'h0, recovery_phase_len = 4'h0;
  logic [23:0] req_addr = 24'h000000, addr_out;
  logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_out, data_in;
  logic [7:0]  stall_cycles = 8'h00;
  logic        req_ready, rsp_valid, chip_select_n, address_latch_strobe, data_oe;
  logic        split_write_strobe_n, split_read_strobe_n, data_strobe_n, read_not_write;
  logic        slow_device_wait_n;
  int          errors = 0, cmp_count = 0;

  always #4 ref_clk = ~ref_clk;

  expansion_bus_async_strobe_timing dut_u (.ref_clk, .reset, .bus_mode, .address_phase_len,
    .data_setup_phase_len, .strobe_phase_len, .hold_phase_len, .recovery_phase_len,
    .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .addr_out, .chip_select_n, .address_latch_strobe, .split_write_strobe_n,
    .split_read_strobe_n, .data_strobe_n, .read_not_write, .data_out, .data_oe, .data_in,
    .slow_device_wait_n);

  bus_peripheral_model peer_u (.addr_out, .ref_clk, .chip_select_n, .split_read_strobe_n,
    .data_strobe_n, .read_not_write, .stall_cycles, .data_in, .slow_device_wait_n);

  // Verdict in one place, also reached by a hung access
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check_count(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Word the peripheral returns for an address
  function automatic logic [15:0] exp_rd(input logic [23:0] ad);
    return {ad[7:0], ad[15:8]} ^ 16'hA5C3;
  endfunction

  // One access; each cycle is sorted into a phase by the pins it shows
  task automatic run_access(input logic [1:0] md, input logic [3:0] a, d, s, h, r,
                            input logic wr, input logic [23:0] ad, input logic [15:0] wd,
                            input logic [7:0] stl);
    int   ale_c = 0, pre_c = 0, set_c = 0, str_c = 0, std_c = 0;
    int   hld_c = 0, rec_c = 0, rsp_c = 0, bad_c = 0, n;
    logic seen_s = 1'b0, seen_h = 1'b0, str, dok;
    @(posedge ref_clk);
    #1;
    {bus_mode, req_write, req_addr, req_wdata, stall_cycles} = {md, wr, ad, wd, stl};
    {address_phase_len, data_setup_phase_len, hold_phase_len} = {a[1:0], d[1:0], h[1:0]};
    {strobe_phase_len, recovery_phase_len, req_valid} = {s, r, 1'b1};
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
    for (n = 0; n < 150; n++)
    begin
      @(negedge ref_clk);
      if (seen_h && req_ready === 1'b1)
        break;
      str = (md != 2'h0) ? data_strobe_n : wr ? split_write_strobe_n : split_read_strobe_n;
      dok = !wr || (data_oe === 1'b1 && data_out === wd);
      ale_c += (address_latch_strobe === 1'b1);
      pre_c += (chip_select_n === 1'b1 && !seen_s && addr_out === ad);
      rsp_c += (rsp_valid === 1'b1);
      bad_c += (chip_select_n === 1'b0 && read_not_write !== !wr);
      if (md == 2'h0)
        bad_c += data_strobe_n !== 1'b1 || (wr ? split_read_strobe_n : split_write_strobe_n) !== 1'b1;
      else
        bad_c += split_write_strobe_n !== 1'b1 || split_read_strobe_n !== 1'b1;
      if (str === 1'b0)
      begin
        seen_s = 1'b1;
        str_c++;
        std_c += dok;
      end
      else if (chip_select_n === 1'b0 && !seen_s)
        set_c += dok;
      else if (chip_select_n === 1'b0)
      begin
        seen_h = 1'b1;
        hld_c += dok && (md == 2'h1 || addr_out === ad);
      end
      else if (seen_h)
        rec_c++;
    end
    if (n == 150)
    begin
      errors++;
      $display("CHECK FAILED t=%0t access never finished", $time);
      complete_run();
    end
    check_count(ale_c, md == 2'h1 ? a + 1 : 0, "latch width");
    check_count(pre_c, md == 2'h1 ? a + 2 : a + 1, "address lead");
    check_count(set_c, d + 1, "setup");
    if (stl == 8'h00)
      check_count(str_c, s + 1, "strobe width");
    else
      check_count(int'(str_c > s + 1 && str_c <= s + stl + 5), 1, "stretched strobe");
    check_count(std_c, str_c, "data in strobe");
    check_count(hld_c, h + 1, "hold");
    check_count(rec_c, r + 1, "recovery");
    check_count(rsp_c, 1, "response pulse");
    check_count(bad_c, 0, "unused strobes and direction");
    if (!wr)
      check_val({8'h00, rsp_rdata}, {8'h00, exp_rd(ad)}, "read data");
  endtask

  // Reset, corner lengths per mode and direction, wait stretch, then random traffic
  initial
  begin
    void'($urandom(32'h51A2283C));
    repeat (4) @(posedge ref_clk);
    #1;
    check_val({15'h0000, split_write_strobe_n, split_read_strobe_n, data_strobe_n,
               chip_select_n, address_latch_strobe, data_oe, read_not_write, req_ready,
               rsp_valid}, 24'h0001E6, "reset pins");
    check_val(addr_out, 24'h000000, "reset address");
    reset = 1'b0;
    for (int m = 0; m < 3; m++)
      for (int w = 0; w < 2; w++)
      begin
        run_access(m[1:0], 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, w[0], 24'h000001, 16'h8001, 8'h00);
        run_access(m[1:0], 4'h3, 4'h3, 4'hF, 4'h3, 4'hF, w[0], 24'hFFFFFF, 16'h7FFE, 8'h00);
        run_access(m[1:0], 4'h0, 4'h3, 4'h3, 4'h0, 4'h1, w[0], 24'h5A5A5A, 16'hC33C, 8'h08);
      end
    for (int i = 0; i < 40; i++)
      run_access(2'($urandom), 4'($urandom % 4), 4'($urandom % 4), 4'($urandom),
                 4'($urandom % 4), 4'($urandom), 1'($urandom), 24'($urandom) | 24'h000001,
                 16'($urandom), 8'h00);
    complete_run();
  end
endmodule  // test_expansion_bus_async_strobe_timing
`default_nettype wire

// >>> verilog/exp_defs.svh
// Constants for the expansion bus strobe timing block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef EXP_DEFS_SVH
`define EXP_DEFS_SVH
`define EXP_ADDR_W      24
`define EXP_DATA_W      16
`define EXP_SHORT_LEN_W 2
`define EXP_LONG_LEN_W  4
`define EXP_CNT_W       4
`define EXP_CNT_ZERO    4'h0
`define EXP_LATCH_LEN   4'h0
`endif

// >>> verilog/exp_pkg.sv
// Types shared by the expansion bus strobe timing design.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package exp_pkg;
  typedef enum logic [1:0] {
    MODE_SPLIT_SIMPLEX = 2'h0,
    MODE_DS_MUX        = 2'h1,
    MODE_DS_SIMPLEX    = 2'h2
  } bus_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_LATCH  = 3'h2,
    ST_SETUP  = 3'h3,
    ST_STROBE = 3'h4,
    ST_HOLD   = 3'h5,
    ST_RECOV  = 3'h6
  } phase_e;

  typedef struct packed {
    logic ale;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ds_n;
    logic rnw;
    logic addr_show;
    logic data_drive;
  } pins_s;
endpackage
`default_nettype wire

// >>> verilog/expansion_bus_async_strobe_timing.sv
// Asynchronous expansion bus access sequencer: split simplex and data-strobe modes.
// Assumes requests and pins are synchronous to ref_clk; wait input is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "exp_defs.svh"
module expansion_bus_async_strobe_timing
  import exp_pkg::*;
(
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic [1:0]                   bus_mode,
  input  wire logic [`EXP_SHORT_LEN_W-1:0]  address_phase_len,
  input  wire logic [`EXP_SHORT_LEN_W-1:0]  data_setup_phase_len,
  input  wire logic [`EXP_LONG_LEN_W-1:0]   strobe_phase_len,
  input  wire logic [`EXP_SHORT_LEN_W-1:0]  hold_phase_len,
  input  wire logic [`EXP_LONG_LEN_W-1:0]   recovery_phase_len,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic                         req_write,
  input  wire logic [`EXP_ADDR_W-1:0]       req_addr,
  input  wire logic [`EXP_DATA_W-1:0]       req_wdata,
  output logic                              rsp_valid,
  output logic [`EXP_DATA_W-1:0]            rsp_rdata,
  output logic [`EXP_ADDR_W-1:0]            addr_out,
  output logic                              chip_select_n,
  output logic                              address_latch_strobe,
  output logic                              split_write_strobe_n,
  output logic                              split_read_strobe_n,
  output logic                              data_strobe_n,
  output logic                              read_not_write,
  output logic [`EXP_DATA_W-1:0]            data_out,
  output logic                              data_oe,
  input  wire logic [`EXP_DATA_W-1:0]       data_in,
  input  wire logic                         slow_device_wait_n
);
  phase_e                   state_r, state_nxt;
  bus_mode_e                mode_r, mode_nxt, mode_cur;
  logic                     write_r, write_nxt;
  logic [`EXP_ADDR_W-1:0]   addr_r, addr_nxt;
  logic [`EXP_DATA_W-1:0]   wdata_r, wdata_nxt;
  logic [13:0]              lens_r, lens_nxt, lens_cur;
  pins_s                    pins_r, pins_nxt;
  logic [`EXP_DATA_W-1:0]   rdata_r, rdata_nxt;
  logic                     rsp_r, rsp_nxt;
  logic                     wait_meta_r, wait_sync_r;
  logic                     accept;
  phase_if                  pif();

  phase_counter u_phase_counter (
    .ref_clk (ref_clk),
    .reset   (reset),
    .pif     (pif)
  );

  // Pin levels for a phase; registered so pins never glitch on decode
  function automatic pins_s pin_decode(phase_e s, bus_mode_e m, logic wr);
    logic mux;
    logic busy;
    logic stb;
    mux  = (m == MODE_DS_MUX);
    busy = (s == ST_SETUP) || (s == ST_STROBE) || (s == ST_HOLD);
    stb  = (s == ST_STROBE);
    pin_decode.ale        = mux && (s == ST_ADDR);
    pin_decode.addr_show  = (s == ST_ADDR) || (s == ST_LATCH) || (!mux && busy);
    pin_decode.cs_n       = !busy;
    pin_decode.wr_n       = !(stb && wr && m == MODE_SPLIT_SIMPLEX);
    pin_decode.rd_n       = !(stb && !wr && m == MODE_SPLIT_SIMPLEX);
    pin_decode.ds_n       = !(stb && m != MODE_SPLIT_SIMPLEX);
    pin_decode.rnw        = !(wr && s != ST_IDLE);
    pin_decode.data_drive = wr && busy;
  endfunction

  // Phase length minus one for the phase being entered
  function automatic logic [3:0] phase_load(phase_e s, logic [13:0] l);
    case (s)
      ST_ADDR:   phase_load = {2'h0, l[13:12]};
      ST_SETUP:  phase_load = {2'h0, l[11:10]};
      ST_STROBE: phase_load = l[9:6];
      ST_HOLD:   phase_load = {2'h0, l[5:4]};
      ST_RECOV:  phase_load = l[3:0];
      default:   phase_load = `EXP_LATCH_LEN;
    endcase
  endfunction

  assign req_ready = (state_r == ST_IDLE);
  assign accept    = req_valid && req_ready;
  assign lens_cur  = accept ? {address_phase_len, data_setup_phase_len, strobe_phase_len,
                               hold_phase_len, recovery_phase_len} : lens_r;
  assign mode_cur  = accept ? bus_mode_e'(bus_mode) : mode_r;

  // Phase sequencing; settings are frozen for the whole access
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    write_nxt = write_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    lens_nxt  = lens_r;
    rdata_nxt = rdata_r;
    rsp_nxt   = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_nxt = ST_ADDR;
          mode_nxt  = mode_cur;
          write_nxt = req_write;
          addr_nxt  = req_addr;
          wdata_nxt = req_wdata;
          lens_nxt  = lens_cur;
        end
      end
      ST_ADDR:
        if (pif.done)
          state_nxt = (mode_r == MODE_DS_MUX) ? ST_LATCH : ST_SETUP;
      ST_LATCH:
        state_nxt = ST_SETUP;
      ST_SETUP:
        if (pif.done)
          state_nxt = ST_STROBE;
      ST_STROBE:
      begin
        // Slow device holds the strobe; wait is seen two cycles late
        if (pif.done && wait_sync_r)
        begin
          state_nxt = ST_HOLD;
          rsp_nxt   = 1'b1;
          if (!write_r)
            rdata_nxt = data_in;
        end
      end
      ST_HOLD:
        if (pif.done)
          state_nxt = ST_RECOV;
      ST_RECOV:
        if (pif.done)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    pins_nxt = pin_decode(state_nxt, mode_nxt, write_nxt);
  end

  // Counter reload on every phase change
  always_comb
  begin
    pif.load     = (state_nxt != state_r);
    pif.load_val = phase_load(state_nxt, lens_nxt);
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_r     <= ST_IDLE;
      mode_r      <= MODE_SPLIT_SIMPLEX;
      write_r     <= 1'b0;
      addr_r      <= '0;
      wdata_r     <= '0;
      lens_r      <= '0;
      rdata_r     <= '0;
      rsp_r       <= 1'b0;
      pins_r      <= pin_decode(ST_IDLE, MODE_SPLIT_SIMPLEX, 1'b0);
      wait_meta_r <= 1'b1;
      wait_sync_r <= 1'b1;
    end
    else
    begin
      state_r     <= state_nxt;
      mode_r      <= mode_nxt;
      write_r     <= write_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      lens_r      <= lens_nxt;
      rdata_r     <= rdata_nxt;
      rsp_r       <= rsp_nxt;
      pins_r      <= pins_nxt;
      wait_meta_r <= slow_device_wait_n;  // Two-stage synchroniser
      wait_sync_r <= wait_meta_r;
    end
  end

  // Pin outputs from flops; addr_out gated by the registered addr_show
  assign address_latch_strobe = pins_r.ale;
  assign chip_select_n        = pins_r.cs_n;
  assign split_write_strobe_n = pins_r.wr_n;
  assign split_read_strobe_n  = pins_r.rd_n;
  assign data_strobe_n        = pins_r.ds_n;
  assign read_not_write       = pins_r.rnw;
  assign data_oe              = pins_r.data_drive;
  assign addr_out             = pins_r.addr_show ? addr_r : '0;
  assign data_out             = wdata_r;
  assign rsp_valid            = rsp_r;
  assign rsp_rdata            = rdata_r;

  // Helper counters for the checks below
  logic [4:0] ale_cnt_r, ale_cnt_nxt, stb_cnt_r, stb_cnt_nxt;
  logic       any_stb_n;
  assign any_stb_n = split_write_strobe_n && split_read_strobe_n && data_strobe_n;
  always_comb
  begin
    ale_cnt_nxt = address_latch_strobe ? ale_cnt_r + 5'h01 : 5'h00;
    stb_cnt_nxt = !any_stb_n ? stb_cnt_r + 5'h01 : 5'h00;
  end
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      ale_cnt_r <= 5'h00;
      stb_cnt_r <= 5'h00;
    end
    else
    begin
      ale_cnt_r <= ale_cnt_nxt;
      stb_cnt_r <= stb_cnt_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Counter seen at the fall edge already holds every high cycle
  ale_pulse_len_a: assert property ($fell(address_latch_strobe) |->
    ale_cnt_r == {3'h0, lens_r[13:12]} + 5'h01 && $past(ale_cnt_r) == {3'h0, lens_r[13:12]})
    else $error("latch strobe width differs from address phase");
  latch_addr_hold_a: assert property ($fell(address_latch_strobe) |->
    $stable(addr_out) ##1 addr_out == '0)
    else $error("address hold after latch strobe is not one cycle");
  latch_to_cs_a: assert property ($fell(address_latch_strobe) |->
    chip_select_n ##1 !chip_select_n)
    else $error("chip select not one cycle after latch strobe");
  simplex_addr_cs_a: assert property ($fell(chip_select_n) && mode_r != MODE_DS_MUX |->
    $stable(addr_out) && $past(state_r) == ST_ADDR)
    else $error("address not valid ahead of chip select");
  simplex_no_ale_a: assert property (mode_r != MODE_DS_MUX |-> !address_latch_strobe)
    else $error("latch strobe active in simplex mode");
  strobe_width_a: assert property ($rose(any_stb_n) |->
    stb_cnt_r >= {1'b0, lens_r[9:6]} + 5'h01)
    else $error("strobe shorter than strobe phase");
  write_hold_a: assert property ($rose(any_stb_n) && write_r |->
    data_oe && !chip_select_n && $stable(data_out))
    else $error("write data or select dropped at strobe release");
  setup_data_a: assert property ($fell(any_stb_n) && write_r |-> $past(data_oe))
    else $error("write data not set up before strobe");
  strobe_data_a: assert property (!any_stb_n && write_r |-> data_oe)
    else $error("write data not driven during strobe");
  recovery_idle_a: assert property ($rose(chip_select_n) |-> !req_ready)
    else $error("no recovery interval after access");
  wait_stretch_a: assert property (state_r == ST_STROBE && !wait_sync_r |=>
    state_r == ST_STROBE)
    else $error("strobe released while wait active");
endmodule // expansion_bus_async_strobe_timing
`default_nettype wire

// >>> verilog/phase_counter.sv
// Down counter that times one phase of an access.
// Assumes load is a one-cycle pulse on phase entry.
`timescale 1ns/1ps
`default_nettype none
`include "exp_defs.svh"
module phase_counter
  import exp_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  phase_if.cnt      pif
);
  logic [`EXP_CNT_W-1:0] cnt_r;
  logic [`EXP_CNT_W-1:0] cnt_nxt;

  // Loaded with length minus one, so done marks the last cycle
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (pif.load)
      cnt_nxt = pif.load_val;
    else if (cnt_r != `EXP_CNT_ZERO)
      cnt_nxt = cnt_r - 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      cnt_r <= `EXP_CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  assign pif.done = (cnt_r == `EXP_CNT_ZERO);
endmodule // phase_counter
`default_nettype wire

// >>> verilog/phase_if.sv
// Load and done handshake between the sequencer and its phase counter.
// Assumes both ends share ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic       load;
  logic [3:0] load_val;
  logic       done;
  modport ctl (output load, output load_val, input done);
  modport cnt (input load, input load_val, output done);
endinterface
`default_nettype wire
